// ===== core/omrb_pkg.sv
package omrb_pkg;

  // Register indexes
  localparam logic [7:0] IDX_HW_REV = 8'h00;
  localparam logic [7:0] IDX_FW_REV = 8'h01;
  localparam logic [7:0] IDX_IO_CTRL = 8'h05;
  localparam logic [7:0] IDX_CLEAR_CTRL = 8'h20;
  localparam logic [7:0] IDX_HORIZ = 8'h21;
  localparam logic [7:0] IDX_VERT = 8'h22;
  localparam logic [7:0] IDX_STATUS = 8'h23;
  localparam logic [7:0] IDX_ORIENT = 8'h27;
  localparam logic [7:0] IDX_FLOOR = 8'h29;
  localparam logic [7:0] IDX_CPI = 8'h2A;
  localparam logic [7:0] IDX_SEARCH = 8'h2F;
  localparam logic [7:0] IDX_FEAT_HI = 8'h31;
  localparam logic [7:0] IDX_FEAT_LO = 8'h32;

  // Serial slave address byte, R/W bit excluded
  localparam logic [7:0] SLAVE_ADDR_BYTE = 8'h20;
  localparam int ADDR_RW_BIT = 0;

  // Pin I/O control fields
  localparam int IO_MOTION_BIT = 0;
  localparam int IO_SLEEP_BIT = 1;
  localparam int IO_POLARITY_BIT = 2;
  localparam int IO_OPEN_DRAIN_BIT = 3;

  // Accumulator clear control fields
  localparam int CLR_NOW_BIT = 0;
  localparam int CLR_AUTO_BIT = 1;

  // Status fields
  localparam int ST_HORIZ_OVF_BIT = 0;
  localparam int ST_VERT_OVF_BIT = 1;
  localparam int ST_IDLE_BIT = 3;

  // Orientation fields
  localparam int OR_INV_X_BIT = 0;
  localparam int OR_INV_Y_BIT = 1;
  localparam int OR_SWAP_BIT = 3;

  // Feature count slice compared with the floor
  localparam int FEAT_SLICE_HI = 13;
  localparam int FEAT_SLICE_LO = 6;

  // Counts-per-inch codes and the shift each applies to raw 3200-cpi motion
  localparam logic [7:0] CPI_400 = 8'h08;
  localparam logic [7:0] CPI_800 = 8'h10;
  localparam logic [7:0] CPI_1600 = 8'h20;
  localparam logic [7:0] CPI_3200 = 8'h40;
  localparam logic [1:0] SHIFT_400 = 2'h3;
  localparam logic [1:0] SHIFT_800 = 2'h2;
  localparam logic [1:0] SHIFT_1600 = 2'h1;
  localparam logic [1:0] SHIFT_3200 = 2'h0;

  // Reset values
  localparam logic RST_INV_X = 1'b0;
  localparam logic RST_INV_Y = 1'b1;
  localparam logic RST_SWAP = 1'b1;
  localparam logic [7:0] RST_FLOOR = 8'h00;
  localparam logic [7:0] RST_CPI = 8'h08;
  localparam logic [7:0] RST_SEARCH = 8'h10;
  localparam logic [7:0] RST_READ = 8'h00;

endpackage

// ===== core/omrb_accumulator.sv
`timescale 1ns/1ps
// Saturating displacement integrator; the reported byte is the integrator
// clamped to 8 bits, and a take removes only what was reported.
module omrb_accumulator #(
  parameter int ACC_W = 12
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic in_valid,
  input wire logic signed [7:0] in_delta,
  input wire logic take,
  output logic signed [7:0] reported,
  output logic overflow
);

  typedef struct packed {
    logic signed [ACC_W-1:0] integ;
    logic signed [7:0] rep;
    logic ovf;
  } omrb_acc_state_t;

  localparam logic signed [ACC_W:0] SUM_MAX = (ACC_W+1)'(2 ** (ACC_W - 1) - 1);
  localparam logic signed [ACC_W:0] SUM_MIN = -SUM_MAX - (ACC_W+1)'(1);
  localparam logic signed [ACC_W-1:0] REP_MAX = ACC_W'(127);
  localparam logic signed [ACC_W-1:0] REP_MIN = -ACC_W'(128);

  initial begin
    if (ACC_W < 9 || ACC_W > 30) begin
      $error("omrb_accumulator: ACC_W must lie in 9..30");
    end
  end

  omrb_acc_state_t st;
  omrb_acc_state_t next_st;

  always_comb begin
    logic signed [ACC_W:0] sum;
    sum = (ACC_W+1)'(st.integ);
    next_st = st;
    if (in_valid) begin
      sum = sum + (ACC_W+1)'(in_delta);
    end
    if (take) begin
      sum = sum - (ACC_W+1)'(st.rep);
    end
    // Clamp instead of wrapping so a fast swipe never flips direction
    if (sum > SUM_MAX) begin
      sum = SUM_MAX;
    end else if (sum < SUM_MIN) begin
      sum = SUM_MIN;
    end
    next_st.integ = sum[ACC_W-1:0];
    next_st.ovf = (sum == SUM_MAX) || (sum == SUM_MIN);
    if (next_st.integ > REP_MAX) begin
      next_st.rep = 8'sh7F;
    end else if (next_st.integ < REP_MIN) begin
      next_st.rep = -8'sh80;
    end else begin
      next_st.rep = next_st.integ[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign reported = st.rep;
  assign overflow = st.ovf;

endmodule

// ===== core/omrb_register_bank.sv
`timescale 1ns/1ps
// Functional notes
// - Full 8-bit register index is decoded; 256 selectable indexes.
// - Device answers serial slave address byte 0x20; master uses it.
// - Index 0x21 reads horizontal displacement since last clear or auto-clear read, signed, resets zero.
// - Index 0x22 reads vertical displacement since last clear or auto-clear read, signed, resets zero.
// - I/O control bit 0 drives the motion pin high or low; resets zero.
// - I/O control bit 1 reads the sampled sleep pin level.
// - I/O control bit 2 selects motion pin polarity; resets zero.
// - I/O control bit 3 selects push-pull or open-drain pin; resets zero.
// - Writing one to 0x20 bit 0 clears reported value from both accumulators.
// - With 0x20 bit 1 set, a displacement read removes its reported value from the integrator.
// - Status 0x23 bit 0 flags horizontal integrator at its limit.
// - Status bit 1 flags vertical integrator at its limit.
// - Status bit 3 set at poll time when no motion arrived since the previous poll.
// - Orientation 0x27 bit 0 inverts horizontal sign; resets zero.
// - Orientation bit 1 inverts vertical sign; resets one.
// - Orientation bit 3 swaps horizontal and vertical; resets one.
// - Feature count bits 13..6 below 0x29 floor force zero motion.
// - Index 0x2A selects 400, 800, 1600 or 3200 counts per inch.
// - Index 0x2F holds minimum search vector, resets 0x10.
// - Auto-clear read removes the reported value; the vertical read returns motion pin inactive unless I/O bit 0 is set or a frame moves in the same cycle.
// - Indexes 0x31 and 0x32 read the current feature count.
module omrb_register_bank #(
  parameter int ACC_W = 12,
  parameter logic [7:0] HW_REVISION = 8'h5A, // Arbitrary value
  parameter logic [3:0] FW_REVISION = 4'h3 // Arbitrary value
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] addr_byte,
  output logic addr_match,
  input wire logic [7:0] reg_index,
  input wire logic wr_strobe,
  input wire logic [7:0] wr_data,
  input wire logic rd_strobe,
  output logic [7:0] rd_data,
  input wire logic frame_valid,
  input wire logic signed [7:0] frame_dx,
  input wire logic signed [7:0] frame_dy,
  input wire logic [15:0] feature_count,
  input wire logic sleep_pin,
  output logic motion_pin_o,
  output logic motion_pin_oe,
  output logic [7:0] search_vector
);

  initial begin
    if (ACC_W < 9 || ACC_W > 30) begin
      $error("omrb_register_bank: ACC_W must lie in 9..30");
    end
  end

  typedef struct packed {
    logic sleep_s1;
    logic sleep_s2;
    logic io_motion;
    logic io_polarity;
    logic io_open_drain;
    logic auto_clear;
    logic [3:0] fw_rev;
    logic inv_x;
    logic inv_y;
    logic swap;
    logic [7:0] floor;
    logic [7:0] cpi;
    logic [7:0] search;
    logic motion_pending;
    logic motion_seen;
    logic idle;
    logic [7:0] rd_data;
  } omrb_state_t;

  omrb_state_t st;
  omrb_state_t next_st;

  // Accumulator side
  logic [1:0] acc_valid;
  logic signed [7:0] acc_delta [2];
  logic [1:0] acc_take;
  logic signed [7:0] acc_rep [2];
  logic [1:0] acc_ovf;

  // Decoded accesses
  logic wr_io;
  logic wr_clear;
  logic clear_now;
  logic rd_horiz;
  logic rd_vert;
  logic gate_open;
  logic [1:0] res_shift;
  logic signed [7:0] sel_x;
  logic signed [7:0] sel_y;
  logic signed [7:0] adj_x;
  logic signed [7:0] adj_y;
  logic frame_moves;
  logic [7:0] read_mux;
  logic motion_active;
  logic pin_level;

  // Slave address comparison ignores the direction bit
  always_comb begin
    logic [7:0] masked;
    masked = addr_byte;
    masked[omrb_pkg::ADDR_RW_BIT] = 1'b0;
    addr_match = (masked == omrb_pkg::SLAVE_ADDR_BYTE);
  end

  // Whole index byte compared, no aliasing
  assign wr_io = wr_strobe && (reg_index == omrb_pkg::IDX_IO_CTRL);
  assign wr_clear = wr_strobe && (reg_index == omrb_pkg::IDX_CLEAR_CTRL);
  assign clear_now = wr_clear && wr_data[omrb_pkg::CLR_NOW_BIT];
  assign rd_horiz = rd_strobe && (reg_index == omrb_pkg::IDX_HORIZ);
  assign rd_vert = rd_strobe && (reg_index == omrb_pkg::IDX_VERT);

  // Low feature count means the surface cannot be trusted
  assign gate_open = !(feature_count[omrb_pkg::FEAT_SLICE_HI:omrb_pkg::FEAT_SLICE_LO] < st.floor);

  // Raw motion arrives at 3200 cpi; coarser settings shift it down
  always_comb begin
    case (st.cpi)
      omrb_pkg::CPI_400: res_shift = omrb_pkg::SHIFT_400;
      omrb_pkg::CPI_800: res_shift = omrb_pkg::SHIFT_800;
      omrb_pkg::CPI_1600: res_shift = omrb_pkg::SHIFT_1600;
      omrb_pkg::CPI_3200: res_shift = omrb_pkg::SHIFT_3200;
      default: res_shift = omrb_pkg::SHIFT_400;
    endcase
  end

  // Orientation applied before integration so a poll never mixes settings
  always_comb begin
    sel_x = st.swap ? frame_dy : frame_dx;
    sel_y = st.swap ? frame_dx : frame_dy;
    adj_x = st.inv_x ? -sel_x : sel_x;
    adj_y = st.inv_y ? -sel_y : sel_y;
    adj_x = adj_x >>> res_shift;
    adj_y = adj_y >>> res_shift;
  end

  assign frame_moves = frame_valid && gate_open && ((adj_x != 8'sh00) || (adj_y != 8'sh00));

  // Per-axis wiring: index 0 horizontal, 1 vertical
  assign acc_delta[0] = adj_x;
  assign acc_delta[1] = adj_y;
  assign acc_take[0] = clear_now || (rd_horiz && st.auto_clear);
  assign acc_take[1] = clear_now || (rd_vert && st.auto_clear);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_axis
      assign acc_valid[g] = frame_valid && gate_open;
      omrb_accumulator #(
        .ACC_W(ACC_W)
      ) u_acc (
        .clock(clock),
        .srst(srst),
        .in_valid(acc_valid[g]),
        .in_delta(acc_delta[g]),
        .take(acc_take[g]),
        .reported(acc_rep[g]),
        .overflow(acc_ovf[g])
      );
    end
  endgenerate

  // Read data for the addressed index; unmapped indexes read zero
  always_comb begin
    read_mux = omrb_pkg::RST_READ;
    case (reg_index)
      omrb_pkg::IDX_HW_REV: read_mux = HW_REVISION;
      omrb_pkg::IDX_FW_REV: read_mux = {4'h0, st.fw_rev};
      omrb_pkg::IDX_IO_CTRL: begin
        read_mux[omrb_pkg::IO_MOTION_BIT] = st.io_motion;
        read_mux[omrb_pkg::IO_SLEEP_BIT] = st.sleep_s2;
        read_mux[omrb_pkg::IO_POLARITY_BIT] = st.io_polarity;
        read_mux[omrb_pkg::IO_OPEN_DRAIN_BIT] = st.io_open_drain;
      end
      omrb_pkg::IDX_CLEAR_CTRL: read_mux[omrb_pkg::CLR_AUTO_BIT] = st.auto_clear;
      omrb_pkg::IDX_HORIZ: read_mux = acc_rep[0];
      omrb_pkg::IDX_VERT: read_mux = acc_rep[1];
      omrb_pkg::IDX_STATUS: begin
        read_mux[omrb_pkg::ST_HORIZ_OVF_BIT] = acc_ovf[0];
        read_mux[omrb_pkg::ST_VERT_OVF_BIT] = acc_ovf[1];
        read_mux[omrb_pkg::ST_IDLE_BIT] = st.idle;
      end
      omrb_pkg::IDX_ORIENT: begin
        read_mux[omrb_pkg::OR_INV_X_BIT] = st.inv_x;
        read_mux[omrb_pkg::OR_INV_Y_BIT] = st.inv_y;
        read_mux[omrb_pkg::OR_SWAP_BIT] = st.swap;
      end
      omrb_pkg::IDX_FLOOR: read_mux = st.floor;
      omrb_pkg::IDX_CPI: read_mux = st.cpi;
      omrb_pkg::IDX_SEARCH: read_mux = st.search;
      omrb_pkg::IDX_FEAT_HI: read_mux = feature_count[15:8];
      omrb_pkg::IDX_FEAT_LO: read_mux = feature_count[7:0];
      default: read_mux = omrb_pkg::RST_READ;
    endcase
  end

  always_comb begin
    next_st = st;
    // Sleep pin is asynchronous; only the second stage is read
    next_st.sleep_s1 = sleep_pin;
    next_st.sleep_s2 = st.sleep_s1;

    if (rd_strobe) begin
      next_st.rd_data = read_mux;
    end

    // Poll time: idle reflects whether any motion arrived since last poll
    if (rd_horiz) begin
      next_st.idle = !st.motion_seen;
      next_st.motion_seen = 1'b0;
    end
    // Set wins over the poll clear
    if (frame_moves) begin
      next_st.motion_seen = 1'b1;
    end

    // Pending motion drops on a clear-now write or a vertical read with auto-clear set
    if (clear_now || (rd_vert && st.auto_clear)) begin
      next_st.motion_pending = 1'b0;
    end
    if (frame_moves) begin
      next_st.motion_pending = 1'b1;
    end

    if (wr_io) begin
      next_st.io_motion = wr_data[omrb_pkg::IO_MOTION_BIT];
      next_st.io_polarity = wr_data[omrb_pkg::IO_POLARITY_BIT];
      next_st.io_open_drain = wr_data[omrb_pkg::IO_OPEN_DRAIN_BIT];
    end
    if (wr_clear) begin
      next_st.auto_clear = wr_data[omrb_pkg::CLR_AUTO_BIT];
    end
    if (wr_strobe) begin
      case (reg_index)
        omrb_pkg::IDX_FW_REV: next_st.fw_rev = wr_data[3:0];
        omrb_pkg::IDX_ORIENT: begin
          next_st.inv_x = wr_data[omrb_pkg::OR_INV_X_BIT];
          next_st.inv_y = wr_data[omrb_pkg::OR_INV_Y_BIT];
          next_st.swap = wr_data[omrb_pkg::OR_SWAP_BIT];
        end
        omrb_pkg::IDX_FLOOR: next_st.floor = wr_data;
        omrb_pkg::IDX_CPI: next_st.cpi = wr_data;
        omrb_pkg::IDX_SEARCH: next_st.search = wr_data;
        // Read-only and undocumented indexes ignore writes
        default: next_st.fw_rev = st.fw_rev;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st <= '0;
      st.fw_rev <= FW_REVISION;
      st.inv_x <= omrb_pkg::RST_INV_X;
      st.inv_y <= omrb_pkg::RST_INV_Y;
      st.swap <= omrb_pkg::RST_SWAP;
      st.floor <= omrb_pkg::RST_FLOOR;
      st.cpi <= omrb_pkg::RST_CPI;
      st.search <= omrb_pkg::RST_SEARCH;
      st.rd_data <= omrb_pkg::RST_READ;
    end else begin
      st <= next_st;
    end
  end

  // Software level and hardware motion both assert the indicator
  assign motion_active = st.io_motion || st.motion_pending;
  assign pin_level = motion_active ^ st.io_polarity;

  // Open drain only ever pulls low; high is released to the pull-up
  assign motion_pin_o = st.io_open_drain ? 1'b0 : pin_level;
  assign motion_pin_oe = st.io_open_drain ? !pin_level : 1'b1;

  assign rd_data = st.rd_data;
  assign search_vector = st.search;

endmodule

// ===== sim/omrb_register_bank_asserts.sv
`timescale 1ns/1ps
module omrb_register_bank_asserts #(
  parameter logic [7:0] HW_REVISION = 8'h5A
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] addr_byte,
  input wire logic addr_match,
  input wire logic [7:0] reg_index,
  input wire logic wr_strobe,
  input wire logic [7:0] wr_data,
  input wire logic rd_strobe,
  input wire logic [7:0] rd_data,
  input wire logic frame_valid,
  input wire logic signed [7:0] frame_dx,
  input wire logic signed [7:0] frame_dy,
  input wire logic [15:0] feature_count,
  input wire logic sleep_pin,
  input wire logic motion_pin_o,
  input wire logic motion_pin_oe,
  input wire logic [7:0] search_vector
);
  logic od_q;
  // Shadow of the output style bit, tracked from writes only
  always_ff @(posedge clock) begin
    if (srst) begin
      od_q <= 1'b0;
    end else if (wr_strobe && reg_index == 8'h05) begin
      od_q <= wr_data[3];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  read_hold_a: assert property (!rd_strobe |=> $stable(rd_data))
    else $error("read data moved without a read");
  unmapped_read_a: assert property (rd_strobe && !(reg_index inside {8'h00, 8'h01, 8'h05, 8'h20,
    8'h21, 8'h22, 8'h23, 8'h27, 8'h29, 8'h2A, 8'h2F, 8'h31, 8'h32}) |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  addr_decode_a: assert property (addr_match == ((addr_byte | 8'h01) == 8'h21))
    else $error("slave address decode wrong");
  search_write_a: assert property (wr_strobe && reg_index == 8'h2F |=> search_vector == $past(wr_data))
    else $error("search vector not written");
  search_hold_a: assert property (!(wr_strobe && reg_index == 8'h2F) |=> $stable(search_vector))
    else $error("search vector moved");
  hw_read_a: assert property (rd_strobe && reg_index == 8'h00 |=> rd_data == HW_REVISION)
    else $error("hardware revision wrong");
  feature_read_a: assert property (rd_strobe && reg_index == 8'h31 |=> rd_data == $past(feature_count[15:8]))
    else $error("feature count high byte wrong");
  push_pull_a: assert property (!od_q |-> motion_pin_oe)
    else $error("push-pull pin not driven");
  open_drain_a: assert property (od_q && motion_pin_oe |-> !motion_pin_o)
    else $error("open-drain pin driven high");
  motion_high_a: assert property (wr_strobe && reg_index == 8'h05 && wr_data[3:0] == 4'h1 |=> motion_pin_o)
    else $error("motion bit did not raise pin");
  polarity_low_a: assert property (wr_strobe && reg_index == 8'h05 && wr_data[3:0] == 4'h5 |=> !motion_pin_o)
    else $error("inverted polarity pin not low");
endmodule

// ===== sim/omrb_host_model.sv
`timescale 1ns/1ps
module omrb_host_model (
  input wire logic clock,
  output logic [7:0] addr_byte = 8'h00,
  output logic [7:0] reg_index = 8'h00,
  output logic wr_strobe = 1'b0,
  output logic [7:0] wr_data = 8'h00,
  output logic rd_strobe = 1'b0
);
  task automatic set_addr(input logic [7:0] a);
    @(posedge clock);
    addr_byte <= a;
  endtask
  task automatic write_reg(input logic [7:0] idx, input logic [7:0] data);
    @(posedge clock);
    // Writes outside the customer map are never issued
    if (idx inside {8'h00, 8'h01, 8'h05, [8'h20:8'h23], 8'h27, 8'h29, 8'h2A, 8'h2F, 8'h31, 8'h32}) begin
      addr_byte <= 8'h20;
      reg_index <= idx;
      wr_data <= data;
      wr_strobe <= 1'b1;
    end
    @(posedge clock);
    wr_strobe <= 1'b0;
    wr_data <= ~data;
    reg_index <= ~idx;
  endtask
  // One multi-byte read with auto-incremented index
  task automatic read_regs(input logic [7:0] idx, input int n);
    @(posedge clock);
    addr_byte <= 8'h21;
    rd_strobe <= 1'b1;
    for (int k = 0; k < n; k++) begin
      reg_index <= idx + 8'(k);
      @(posedge clock);
    end
    rd_strobe <= 1'b0;
    reg_index <= ~idx;
  endtask
endmodule

// ===== sim/omrb_register_bank_tb.sv
`timescale 1ns/1ps
module omrb_register_bank_tb;
  localparam logic [7:0] HW_ID = 8'h3C; // Arbitrary identity value
  localparam logic [7:0] RI [10] = '{8'h00, 8'h01, 8'h05, 8'h20, 8'h23, 8'h27, 8'h29, 8'h2A, 8'h2F, 8'h77};
  localparam logic [7:0] RE [10] = '{HW_ID, 8'h03, 8'h00, 8'h00, 8'h00, 8'h0A, 8'h00, 8'h08, 8'h10, 8'h00};
  localparam logic [7:0] AD [4] = '{8'h20, 8'h21, 8'h22, 8'hA1};
  localparam logic [7:0] IO [4] = '{8'h01, 8'h05, 8'h09, 8'h0D};
  localparam logic [7:0] CPI [4] = '{8'h08, 8'h10, 8'h20, 8'h40};
  localparam logic [7:0] ORI [4] = '{8'h0B, 8'h01, 8'h02, 8'h08};
  logic clock = 1'b0, srst = 1'b1, sleep_pin = 1'b0, frame_valid = 1'b0, rd_seen = 1'b0;
  logic addr_match, motion_pin_o, motion_pin_oe, wr_strobe, rd_strobe;
  logic [7:0] addr_byte, reg_index, wr_data, rd_data, search_vector, dx, dy;
  logic signed [7:0] frame_dx = 8'h00, frame_dy = 8'h00;
  logic [15:0] feature_count = 16'h0040;
  logic [7:0] expq [$];
  int checks = 0, mismatches = 0;
  always #12.5 clock = ~clock;
  omrb_register_bank #(.HW_REVISION(HW_ID)) i_omrb_register_bank (.clock, .srst, .addr_byte, .addr_match,
    .reg_index, .wr_strobe, .wr_data, .rd_strobe, .rd_data, .frame_valid, .frame_dx, .frame_dy,
    .feature_count, .sleep_pin, .motion_pin_o, .motion_pin_oe, .search_vector);
  omrb_host_model i_omrb_host_model (.clock, .addr_byte, .reg_index, .wr_strobe, .wr_data, .rd_strobe);
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    expq.push_back(e);
    i_omrb_host_model.read_regs(idx, 1);
  endtask
  task automatic poll(input logic [7:0] ex, input logic [7:0] ey);
    expq.push_back(ex);
    expq.push_back(ey);
    i_omrb_host_model.read_regs(8'h21, 2);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    i_omrb_host_model.write_reg(idx, d);
  endtask
  task automatic frame(input logic [7:0] x, input logic [7:0] y);
    @(posedge clock);
    frame_valid <= 1'b1;
    frame_dx <= x;
    frame_dy <= y;
    @(posedge clock);
    frame_valid <= 1'b0;
    frame_dx <= ~x;
    frame_dy <= ~y;
  endtask
  // Swap first, then sign, then scale down from 3200 counts per inch
  function automatic logic [7:0] axis(logic [7:0] a, logic [7:0] b, logic sw, logic inv, int sh);
    logic signed [7:0] v;
    v = sw ? b : a;
    v = inv ? -v : v;
    return v >>> sh;
  endfunction
  // Read data lands exactly one cycle after its strobe
  always @(posedge clock) begin
    if (rd_seen) check("rd_data", rd_data, (expq.size() > 0) ? expq.pop_front() : 8'hXX);
    rd_seen <= rd_strobe;
  end
  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    give_verdict();
  end
  initial begin
    int fw;
    fw = $urandom(32'h76C752D1);
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    for (int i = 0; i < 10; i++) rd(RI[i], RE[i]);
    // Auto-clear goes on before the first displacement poll
    wr(8'h20, 8'h02);
    poll(8'h00, 8'h00);
    foreach (AD[i]) begin
      i_omrb_host_model.set_addr(AD[i]);
      #1 check("addr_match", {7'h0, addr_match}, {7'h0, (AD[i] | 8'h01) == 8'h21});
    end
    fw = $urandom_range(15);
    wr(8'h01, 8'(fw));
    rd(8'h01, 8'(fw));
    wr(8'h21, 8'h55);
    poll(8'h00, 8'h00);
    wr(8'h2F, 8'h40);
    #1 check("search_vector", search_vector, 8'h40);
    wr(8'h2F, 8'h10);
    #1 check("search_vector", search_vector, 8'h10);
    @(posedge clock);
    sleep_pin <= 1'b1;
    repeat (3) @(posedge clock);
    rd(8'h05, 8'h02);
    foreach (IO[i]) begin
      wr(8'h05, IO[i]);
      #1 check("motion_pin_oe", {7'h0, motion_pin_oe}, {7'h0, IO[i] != 8'h09});
      if (IO[i] != 8'h09) check("motion_pin_o", {7'h0, motion_pin_o}, {7'h0, IO[i][0] ^ IO[i][2]});
    end
    rd(8'h05, 8'h0F);
    wr(8'h05, 8'h00);
    wr(8'h27, 8'h00);
    wr(8'h2A, 8'h40);
    frame(8'h05, 8'hFD);
    #1 check("motion_pin_o", {7'h0, motion_pin_o}, 8'h01);
    frame(8'h02, 8'h01);
    poll(8'h07, 8'hFE);
    #1 check("motion_pin_o", {7'h0, motion_pin_o}, 8'h00);
    rd(8'h23, 8'h00);
    poll(8'h00, 8'h00);
    rd(8'h23, 8'h08);
    for (int i = 0; i < 4; i++) begin
      dx = 8'($urandom_range(127)) - 8'h40;
      dy = 8'($urandom_range(127)) - 8'h40;
      wr(8'h2A, CPI[i]);
      wr(8'h27, ORI[i]);
      frame(dx, dy);
      poll(axis(dx, dy, ORI[i][3], ORI[i][0], 3 - i),
        axis(dy, dx, ORI[i][3], ORI[i][1], 3 - i));
    end
    // Unlisted resolution code scales as 400 cpi but reads back as written
    wr(8'h2A, 8'h33);
    frame(8'h40, 8'h40);
    poll(8'h08, 8'h08);
    rd(8'h2A, 8'h33);
    wr(8'h27, 8'h00);
    wr(8'h2A, 8'h40);
    wr(8'h29, 8'h05);
    feature_count <= 16'h0100;
    frame(8'h14, 8'h14);
    poll(8'h00, 8'h00);
    rd(8'h31, 8'h01);
    rd(8'h32, 8'h00);
    feature_count <= 16'h0140;
    frame(8'h14, 8'h14);
    poll(8'h14, 8'h14);
    wr(8'h20, 8'h00);
    repeat (25) frame(8'h7F, 8'h80);
    rd(8'h23, 8'h03);
    poll(8'h7F, 8'h80);
    poll(8'h7F, 8'h80);
    wr(8'h20, 8'h01);
    rd(8'h20, 8'h00);
    rd(8'h23, 8'h08);
    poll(8'h7F, 8'h80);
    repeat (3) @(posedge clock);
    give_verdict();
  end
endmodule
bind omrb_register_bank omrb_register_bank_asserts #(.HW_REVISION(HW_REVISION)) i_omrb_register_bank_asserts (
  .clock, .srst, .addr_byte, .addr_match, .reg_index, .wr_strobe, .wr_data, .rd_strobe, .rd_data, .frame_valid,
  .frame_dx, .frame_dy, .feature_count, .sleep_pin, .motion_pin_o, .motion_pin_oe, .search_vector);
